// ### mp_serial_pkg.sv
// Constants shared by the multiprocessor serial channel design.
// Assumes a single 250 MHz clock and a plain strobe register port.
package mp_serial_pkg;
  // ----------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS = 4'h0;    // Control register.
  localparam logic [3:0] STAT_OFS = 4'h1;    // Status register.
  localparam logic [3:0] RXDATA_OFS = 4'h2;  // Receive data register.
  localparam logic [3:0] TXDATA_OFS = 4'h3;  // Transmit data, bit 8 is the MP bit.
  localparam logic [3:0] BAUD_OFS = 4'h4;    // Bit period in clocks minus one.
  localparam logic [3:0] IRQ_STAT_OFS = 4'h5; // Sticky event status.
  localparam logic [3:0] IRQ_CLR_OFS = 4'h6;  // Write one to clear.
  localparam logic [3:0] IRQ_EN_OFS = 4'h7;   // Event enables.
  // ----------------------------------------------------------------
  // Control bit positions.
  // ----------------------------------------------------------------
  localparam int CTRL_MP_FMT = 0;   // Multiprocessor format select.
  localparam int CTRL_PAR_EN = 1;   // Parity enable.
  localparam int CTRL_PAR_ODD = 2;  // Odd parity.
  localparam int CTRL_STOP2 = 3;    // Two stop bits.
  localparam int CTRL_WAIT_EN = 4;  // Id_wait_enable.
  localparam int CTRL_RX_IRQ_EN = 5; // Receive_irq_enable.
  localparam int CTRL_RX_EN = 6;    // Receiver enable.
  localparam int CTRL_TX_EN = 7;    // Transmitter enable.
  // ----------------------------------------------------------------
  // Status bit positions and event bits.
  // ----------------------------------------------------------------
  localparam int STAT_RX_FULL = 0;  // Receive_full_flag.
  localparam int STAT_FRAME = 1;    // Framing_error_flag.
  localparam int STAT_OVERRUN = 2;  // Overrun_error_flag.
  localparam int STAT_PARITY = 3;   // Parity error flag.
  localparam int STAT_ID = 4;       // Received_id_flag.
  localparam int STAT_TX_BUSY = 5;  // Transmitter busy.
  localparam int EV_RX = 0;         // Receive or ID event.
  localparam int EV_ERR = 1;        // Receive error event.
  localparam int EV_TX = 2;         // Transmit done event.
  localparam int EV_W = 3;          // Event register width.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0021;
  localparam logic [3:0] BITS_MAX = 4'hb; // Start, 8 data, MP or parity, 1 stop.
  localparam int CHANNELS = 3;
  localparam int CLK_ONLY_ASYNC_CH = 1;   // Channel with no clock pin.
  // ----------------------------------------------------------------
  // Receiver states.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } rx_state_t;
endpackage : mp_serial_pkg

// ### mp_serial_channel.sv
// One asynchronous serial channel with multiprocessor addressing.
// Assumes receive_pin is synchronous to i_ref_clk; the serial clock pin is
// unused in asynchronous mode and is left as an idle input.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module mp_serial_channel (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_receive_pin,
  output logic o_transmit_pin,
  input wire logic i_serial_clock_pin,
  output logic o_serial_clock_pin,
  output logic o_serial_clock_pin_oe,
  output logic o_receive_irq,
  output logic o_irq
);
  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic [7:0] serial_control_reg_r;  // Control bits.
  logic [15:0] baud_r;               // Bit period minus one, shared by all formats.
  logic [7:0] receive_data_reg_r;    // Received character.
  logic [8:0] tx_hold_r;             // Character and MP bit to send.
  logic tx_pend_r;                   // Transmit hold register loaded.
  logic rx_full_r;                   // Receive_full_flag.
  logic frame_err_r;                 // Framing_error_flag.
  logic overrun_r;                   // Overrun_error_flag.
  logic parity_err_r;                // Parity error flag.
  logic id_flag_r;                   // Received_id_flag.
  logic [mp_serial_pkg::EV_W-1:0] ev_stat_r;  // Sticky events.
  logic [mp_serial_pkg::EV_W-1:0] ev_en_r;    // Event enables.
  logic [mp_serial_pkg::EV_W-1:0] ev_set;     // Event pulses.
  logic mp_fmt;                      // Multiprocessor format in use.
  logic par_on;                      // Parity actually framed.
  logic wait_en;                     // Id_wait_enable.
  // Parity enable has no effect in multiprocessor format.
  assign mp_fmt = serial_control_reg_r[mp_serial_pkg::CTRL_MP_FMT];
  assign par_on = serial_control_reg_r[mp_serial_pkg::CTRL_PAR_EN] & ~mp_fmt;
  assign wait_en = serial_control_reg_r[mp_serial_pkg::CTRL_WAIT_EN];
  // Serial clock pin is never driven in asynchronous operation.
  assign o_serial_clock_pin = 1'b0;
  assign o_serial_clock_pin_oe = 1'b0;
  // ----------------------------------------------------------------
  // Receiver.
  // ----------------------------------------------------------------
  mp_serial_pkg::rx_state_t rx_st_r;
  logic [15:0] rx_cnt_r;     // Clocks left in the current bit.
  logic [3:0] rx_bit_r;      // Index of the bit being sampled.
  logic [9:0] rx_shift_r;    // Receive_shift_reg: data then extra bit.
  logic rx_done;             // Character complete this cycle.
  logic rx_extra;            // Multiprocessor or parity bit.
  logic rx_stop_ok;          // Stop bit sampled high.
  logic [3:0] rx_last;       // Index of the first stop bit.
  assign rx_last = (mp_fmt | par_on) ? 4'h9 : 4'h8;
  assign rx_extra = rx_shift_r[8];
  // Sample in the middle of each bit at the asynchronous bit rate.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      rx_st_r <= mp_serial_pkg::RX_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 4'h0;
      rx_shift_r <= 10'h000;
    end
    else
    begin
      unique case (rx_st_r)
        mp_serial_pkg::RX_IDLE:
        begin
          // A low level on the receive pin starts a character.
          if (serial_control_reg_r[mp_serial_pkg::CTRL_RX_EN] && !i_receive_pin)
          begin
            rx_st_r <= mp_serial_pkg::RX_START;
            rx_cnt_r <= {1'b0, baud_r[15:1]};
          end
        end
        mp_serial_pkg::RX_START:
        begin
          if (rx_cnt_r == 16'h0000)
          begin
            // A high level at mid start is a glitch.
            rx_st_r <= i_receive_pin ? mp_serial_pkg::RX_IDLE : mp_serial_pkg::RX_BITS;
            rx_cnt_r <= baud_r;
            rx_bit_r <= 4'h0;
          end
          else
          begin
            rx_cnt_r <= rx_cnt_r - 16'h0001;
          end
        end
        mp_serial_pkg::RX_BITS:
        begin
          if (rx_cnt_r == 16'h0000)
          begin
            // Bits arrive least significant first, extra bit after data.
            if (rx_bit_r < 4'h8)
            begin
              rx_shift_r[rx_bit_r[2:0]] <= i_receive_pin;
            end
            else if (rx_bit_r == 4'h8 && rx_last == 4'h9)
            begin
              rx_shift_r[8] <= i_receive_pin;
            end
            rx_shift_r[9] <= i_receive_pin;
            rx_cnt_r <= baud_r;
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == rx_last)
            begin
              rx_st_r <= mp_serial_pkg::RX_IDLE;
            end
          end
          else
          begin
            rx_cnt_r <= rx_cnt_r - 16'h0001;
          end
        end
        default:
        begin
          rx_st_r <= mp_serial_pkg::RX_IDLE;
        end
      endcase
    end
  end
  // A character completes when the first stop bit is sampled.
  assign rx_done = (rx_st_r == mp_serial_pkg::RX_BITS) && (rx_cnt_r == 16'h0000) && (rx_bit_r == rx_last);
  assign rx_stop_ok = i_receive_pin;
  // ----------------------------------------------------------------
  // Receive acceptance and status flags.
  // ----------------------------------------------------------------
  logic rx_is_id;      // Completed character is an ID character.
  logic rx_accept;     // Character passes to the data register.
  logic rx_par_bad;    // Parity mismatch.
  logic rd_data;       // Software reads receive data.
  logic wr_stat;       // Software writes status.
  assign rx_is_id = rx_done & mp_fmt & rx_extra;
  // Data characters in wait mode are skipped entirely.
  assign rx_accept = rx_done & ~(mp_fmt & wait_en & ~rx_extra);
  assign rx_par_bad = par_on & (rx_extra != (^rx_shift_r[7:0] ^ serial_control_reg_r[mp_serial_pkg::CTRL_PAR_ODD]));
  assign rd_data = i_rd && (i_addr == mp_serial_pkg::RXDATA_OFS);
  assign wr_stat = i_wr && (i_addr == mp_serial_pkg::STAT_OFS);
  // Flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      receive_data_reg_r <= 8'h00;
      rx_full_r <= 1'b0;
      frame_err_r <= 1'b0;
      overrun_r <= 1'b0;
      parity_err_r <= 1'b0;
      id_flag_r <= 1'b0;
    end
    else
    begin
      if (rx_accept && !rx_full_r)
      begin
        receive_data_reg_r <= rx_shift_r[7:0];
      end
      // Full clears on a data read or a status write of zero.
      if (rx_accept && !rx_full_r)
      begin
        rx_full_r <= 1'b1;
      end
      else if (rd_data || (wr_stat && !i_wdata[mp_serial_pkg::STAT_RX_FULL]))
      begin
        rx_full_r <= 1'b0;
      end
      if (rx_accept && !rx_stop_ok)
      begin
        frame_err_r <= 1'b1;
      end
      else if (wr_stat && !i_wdata[mp_serial_pkg::STAT_FRAME])
      begin
        frame_err_r <= 1'b0;
      end
      if (rx_accept && rx_full_r)
      begin
        overrun_r <= 1'b1;
      end
      else if (wr_stat && !i_wdata[mp_serial_pkg::STAT_OVERRUN])
      begin
        overrun_r <= 1'b0;
      end
      if (rx_accept && rx_par_bad)
      begin
        parity_err_r <= 1'b1;
      end
      else if (wr_stat && !i_wdata[mp_serial_pkg::STAT_PARITY])
      begin
        parity_err_r <= 1'b0;
      end
      // Received_id_flag follows the MP bit of each accepted character.
      if (rx_accept && mp_fmt)
      begin
        id_flag_r <= rx_extra;
      end
    end
  end
  // ----------------------------------------------------------------
  // Transmitter.
  // ----------------------------------------------------------------
  logic [15:0] tx_cnt_r;   // Clocks left in current bit.
  logic [3:0] tx_bit_r;    // Bits left to send.
  logic [11:0] tx_sh_r;    // Frame shift, LSB out first.
  logic tx_busy_r;         // Frame in progress.
  logic tx_done;           // Frame ends this cycle.
  logic [3:0] tx_len;      // Bits in one frame.
  logic tx_ex;             // Extra bit value.
  assign tx_ex = mp_fmt ? tx_hold_r[8] : (^tx_hold_r[7:0] ^ serial_control_reg_r[mp_serial_pkg::CTRL_PAR_ODD]);
  // Start, eight data bits and one stop bit, plus the extra bit and a second stop when each is selected.
  assign tx_len = 4'ha + {3'h0, mp_fmt | par_on} + {3'h0, serial_control_reg_r[mp_serial_pkg::CTRL_STOP2]};
  assign tx_done = tx_busy_r && (tx_cnt_r == 16'h0000) && (tx_bit_r == 4'h1);
  // Frame is start, data LSB first, MP or parity bit, then stop bits.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 12'hfff;
    end
    else if (!tx_busy_r)
    begin
      if (tx_pend_r && serial_control_reg_r[mp_serial_pkg::CTRL_TX_EN])
      begin
        tx_busy_r <= 1'b1;
        tx_cnt_r <= baud_r;
        tx_bit_r <= tx_len;
        if (mp_fmt || par_on)
        begin
          tx_sh_r <= {2'b11, tx_ex, tx_hold_r[7:0], 1'b0};
        end
        else
        begin
          tx_sh_r <= {3'b111, tx_hold_r[7:0], 1'b0};
        end
      end
    end
    else if (tx_cnt_r == 16'h0000)
    begin
      tx_cnt_r <= baud_r;
      tx_bit_r <= tx_bit_r - 4'h1;
      tx_sh_r <= {1'b1, tx_sh_r[11:1]};
      tx_busy_r <= ~tx_done;
    end
    else
    begin
      tx_cnt_r <= tx_cnt_r - 16'h0001;
    end
  end
  assign o_transmit_pin = tx_sh_r[0];
  // ----------------------------------------------------------------
  // Register writes.
  // ----------------------------------------------------------------
  logic tx_load;   // Frame start consumes the hold register.
  assign tx_load = !tx_busy_r && tx_pend_r && serial_control_reg_r[mp_serial_pkg::CTRL_TX_EN];
  // Control, baud and transmit hold; an ID character clears wait-enable.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      serial_control_reg_r <= mp_serial_pkg::CTRL_RST;
      baud_r <= mp_serial_pkg::BAUD_RST;
      tx_hold_r <= 9'h000;
      tx_pend_r <= 1'b0;
      ev_en_r <= '0;
    end
    else
    begin
      if (i_wr && i_addr == mp_serial_pkg::CTRL_OFS)
      begin
        serial_control_reg_r <= i_wdata[7:0];
      end
      if (rx_is_id && wait_en)
      begin
        serial_control_reg_r[mp_serial_pkg::CTRL_WAIT_EN] <= 1'b0;
      end
      if (i_wr && i_addr == mp_serial_pkg::BAUD_OFS)
      begin
        baud_r <= i_wdata;
      end
      if (i_wr && i_addr == mp_serial_pkg::IRQ_EN_OFS)
      begin
        ev_en_r <= i_wdata[mp_serial_pkg::EV_W-1:0];
      end
      if (i_wr && i_addr == mp_serial_pkg::TXDATA_OFS)
      begin
        tx_hold_r <= i_wdata[8:0];
        tx_pend_r <= 1'b1;
      end
      else if (tx_load)
      begin
        tx_pend_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Events and interrupts.
  // ----------------------------------------------------------------
  assign ev_set[mp_serial_pkg::EV_RX] = rx_accept;
  assign ev_set[mp_serial_pkg::EV_ERR] = rx_accept & (~rx_stop_ok | rx_full_r | rx_par_bad);
  assign ev_set[mp_serial_pkg::EV_TX] = tx_done;
  // Sticky status; a set in the clearing cycle wins.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ev_stat_r <= '0;
    end
    else if (i_wr && i_addr == mp_serial_pkg::IRQ_CLR_OFS)
    begin
      ev_stat_r <= (ev_stat_r & ~i_wdata[mp_serial_pkg::EV_W-1:0]) | ev_set;
    end
    else
    begin
      ev_stat_r <= ev_stat_r | ev_set;
    end
  end
  assign o_irq = |(ev_stat_r & ev_en_r);
  // Receive interrupt follows the full flag, gated by the enable bit.
  assign o_receive_irq = rx_full_r & serial_control_reg_r[mp_serial_pkg::CTRL_RX_IRQ_EN];
  // ----------------------------------------------------------------
  // Read port: data in the cycle after the strobe.
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= 16'h0000;
    end
    else if (i_rd)
    begin
      unique case (i_addr)
        mp_serial_pkg::CTRL_OFS: o_rdata <= {8'h00, serial_control_reg_r};
        mp_serial_pkg::STAT_OFS: o_rdata <= {10'h000, tx_busy_r, id_flag_r, parity_err_r, overrun_r,
                                              frame_err_r, rx_full_r};
        mp_serial_pkg::RXDATA_OFS: o_rdata <= {8'h00, receive_data_reg_r};
        mp_serial_pkg::TXDATA_OFS: o_rdata <= {7'h00, tx_hold_r};
        mp_serial_pkg::BAUD_OFS: o_rdata <= baud_r;
        mp_serial_pkg::IRQ_STAT_OFS: o_rdata <= {13'h0000, ev_stat_r};
        mp_serial_pkg::IRQ_EN_OFS: o_rdata <= {13'h0000, ev_en_r};
        default: o_rdata <= 16'h0000;
      endcase
    end
    else
    begin
      o_rdata <= 16'h0000;
    end
  end
  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  chk_wait_blocks_full: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (rx_done && mp_fmt && wait_en && !rx_extra && !rx_full_r) |=> !rx_full_r)
    else $error("Data character set full flag during ID wait.");
  chk_id_clears_wait: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (rx_is_id && wait_en && !(i_wr && i_addr == mp_serial_pkg::CTRL_OFS)) |=> (!wait_en && id_flag_r))
    else $error("ID character did not clear wait-enable.");
  chk_id_irq_raise: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (rx_is_id && !rx_full_r && serial_control_reg_r[mp_serial_pkg::CTRL_RX_IRQ_EN]
     && !(i_wr && i_addr == mp_serial_pkg::CTRL_OFS)) |=> o_receive_irq)
    else $error("ID character did not raise receive interrupt.");
  chk_mp_no_parity: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    mp_fmt |-> !par_on)
    else $error("Parity active in multiprocessor format.");
  chk_clk_pin_idle: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !o_serial_clock_pin_oe)
    else $error("Serial clock pin driven.");
  chk_tx_start_bit: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    tx_load |=> !o_transmit_pin)
    else $error("Frame did not open with a low start bit.");
  chk_bit_period: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (rx_st_r == mp_serial_pkg::RX_BITS && rx_cnt_r == 16'h0000 && !rx_done) |=> rx_cnt_r == $past(baud_r))
    else $error("Bit period reload wrong.");
  chk_read_latency: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_rd |=> o_rdata == 16'h0000)
    else $error("Read data outside the answer cycle.");
endmodule : mp_serial_channel

// ### mp_station_model.sv
// Far-side station sharing the serial lines with the channel under test.
// Assumes both sides use the same bit period, given here in clocks.
`timescale 1ns/1ps
module mp_station_model #(
  parameter int BIT_CLKS = 16 // Clocks per serial bit.
) (
  input wire logic i_clk,
  input wire logic i_line_in,
  output logic o_line_out
);
  // ----------------------------------------------------------------
  // Line driver.
  // ----------------------------------------------------------------
  // The line rests high between frames, as a pulled-up idle line would.
  initial o_line_out = 1'b1;

  // Holds one bit level on the line for a whole bit period.
  task automatic put_bit(input logic v);
    @(posedge i_clk);
    o_line_out <= v;
    repeat (BIT_CLKS - 1) @(posedge i_clk);
  endtask : put_bit

  // Sends start, data LSB first, the address marker bit, then one stop bit.
  // A low stop level is used to provoke a framing fault on purpose.
  task automatic send_char(input logic [7:0] d, input logic mp, input logic stop_lvl);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++)
    begin
      put_bit(d[i]);
    end
    put_bit(mp);
    put_bit(stop_lvl);
    @(posedge i_clk);
    o_line_out <= 1'b1;
  endtask : send_char

  // ----------------------------------------------------------------
  // Line receiver.
  // ----------------------------------------------------------------
  // Waits for a start edge and samples each data bit and the marker bit in its middle.
  task automatic recv_char(output logic [7:0] d, output logic mp);
    @(negedge i_line_in);
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CLKS) @(posedge i_clk);
      d[i] = i_line_in;
    end
    repeat (BIT_CLKS) @(posedge i_clk);
    mp = i_line_in;
  endtask : recv_char
endmodule : mp_station_model

// ### tb.sv
// Self-checking bench for one multiprocessor serial channel.
// Assumes the station model on the serial lines and a strobe register port.
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Signals and instances.
  // ----------------------------------------------------------------
  localparam int BIT_CLKS = 16; // Shortened bit period for a quick run.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] rdata;
  logic rx_line;
  logic tx_line;
  logic sck_out;
  logic sck_oe;
  logic rx_irq;
  logic irq;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] got_d;
  logic got_mp;

  // Free-running clock at 4 ns.
  always #2 clk = ~clk;

  mp_serial_channel dut (
    .i_ref_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_receive_pin(rx_line),
    .o_transmit_pin(tx_line), .i_serial_clock_pin(1'b0),
    .o_serial_clock_pin(sck_out), .o_serial_clock_pin_oe(sck_oe),
    .o_receive_irq(rx_irq), .o_irq(irq)
  );

  mp_station_model #(.BIT_CLKS(BIT_CLKS)) peer (
    .i_clk(clk), .i_line_in(tx_line), .o_line_out(rx_line)
  );

  // ----------------------------------------------------------------
  // Bus and check tasks.
  // ----------------------------------------------------------------
  // Compares a seen value with the expected one and counts both.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe with address and data.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the data stand in the following cycle only.
  task automatic rchk(input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    check(rdata & mask, exp);
  endtask : rchk

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Watchdog: the sequence needs a few thousand cycles at most.
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped index.
    rchk(mp_serial_pkg::CTRL_OFS, 16'hffff, 16'h0000);
    rchk(mp_serial_pkg::BAUD_OFS, 16'hffff, 16'h0021);
    rchk(mp_serial_pkg::STAT_OFS, 16'hffff, 16'h0000);
    wr(4'h9, 16'h1234);
    rchk(4'h9, 16'hffff, 16'h0000);
    check({14'h0000, sck_oe, sck_out}, 16'h0000);
    // Shorter bit period; parity enable set as well, to be ignored.
    wr(mp_serial_pkg::BAUD_OFS, 16'(BIT_CLKS - 1));
    rchk(mp_serial_pkg::BAUD_OFS, 16'hffff, 16'(BIT_CLKS - 1));
    wr(mp_serial_pkg::IRQ_EN_OFS, 16'h0007);
    wr(mp_serial_pkg::CTRL_OFS, 16'h00f3);
    // Data characters while waiting for an ID are skipped, even a faulty one.
    peer.send_char(8'h5a, 1'b0, 1'b1);
    rchk(mp_serial_pkg::STAT_OFS, 16'h000f, 16'h0000);
    peer.send_char(8'h33, 1'b0, 1'b0);
    rchk(mp_serial_pkg::STAT_OFS, 16'h000f, 16'h0000);
    rchk(mp_serial_pkg::IRQ_STAT_OFS, 16'h0007, 16'h0000);
    check({15'h0000, rx_irq}, 16'h0000);
    // An ID character ends the wait and raises the receive interrupt.
    peer.send_char(8'ha7, 1'b1, 1'b1);
    rchk(mp_serial_pkg::STAT_OFS, 16'h001f, 16'h0011);
    rchk(mp_serial_pkg::CTRL_OFS, 16'hffff, 16'h00e3);
    check({15'h0000, rx_irq}, 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    rchk(mp_serial_pkg::RXDATA_OFS, 16'h00ff, 16'h00a7);
    check({15'h0000, rx_irq}, 16'h0000);
    // Data now flows; odd ones count with a low marker bit, no parity fault.
    peer.send_char(8'h3d, 1'b0, 1'b1);
    rchk(mp_serial_pkg::STAT_OFS, 16'h000f, 16'h0001);
    rchk(mp_serial_pkg::RXDATA_OFS, 16'h00ff, 16'h003d);
    // Errors are detected again once the wait has ended.
    peer.send_char(8'h81, 1'b0, 1'b0);
    rchk(mp_serial_pkg::STAT_OFS, 16'h0002, 16'h0002);
    rchk(mp_serial_pkg::IRQ_STAT_OFS, 16'h0002, 16'h0002);
    // Interrupt masked, then cleared.
    wr(mp_serial_pkg::IRQ_EN_OFS, 16'h0000);
    @(posedge clk);
    #1;
    check({15'h0000, irq}, 16'h0000);
    wr(mp_serial_pkg::IRQ_CLR_OFS, 16'h0007);
    wr(mp_serial_pkg::STAT_OFS, 16'h0000);
    wr(mp_serial_pkg::IRQ_EN_OFS, 16'h0007);
    rchk(mp_serial_pkg::IRQ_STAT_OFS, 16'h0007, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    // Transmit an ID character; the marker bit replaces parity on the wire.
    fork
      peer.recv_char(got_d, got_mp);
      wr(mp_serial_pkg::TXDATA_OFS, 16'h01a5);
    join
    check({8'h00, got_d}, 16'h00a5);
    check({15'h0000, got_mp}, 16'h0001);
    // The stop bit still belongs to the frame: busy stays up through it.
    repeat (BIT_CLKS) @(posedge clk);
    rchk(mp_serial_pkg::STAT_OFS, 16'h0020, 16'h0020);
    repeat (4 * BIT_CLKS) @(posedge clk);
    rchk(mp_serial_pkg::IRQ_STAT_OFS, 16'h0004, 16'h0004);
    check({15'h0000, irq}, 16'h0001);
    // Plain format with even parity: a wrong parity bit is flagged.
    wr(mp_serial_pkg::STAT_OFS, 16'h0000);
    wr(mp_serial_pkg::CTRL_OFS, 16'h0042);
    peer.send_char(8'h3d, 1'b0, 1'b1);
    rchk(mp_serial_pkg::STAT_OFS, 16'h001f, 16'h0009);
    stop_test();
  end
endmodule : tb
